// file: logic/uart_shadow_pkg.sv
// Shared constants and carrier types for the UART shadow data port.
// Assumes a 32-bit classic Wishbone master and byte-wide character strobes.
package uart_shadow_pkg;

  // ==========================================================
  // Widths and depths
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned LEVEL_W = 5;
  localparam int unsigned CTRL_W = 2;
  localparam int unsigned INT_W = 3;

  // ==========================================================
  // Register byte addresses
  localparam logic [ADDR_W-1:0] SHADOW_FIRST_ADDR = 32'h5000_1030;
  localparam logic [ADDR_W-1:0] SHADOW_LAST_ADDR = 32'h5000_106C;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 32'h5000_1100;
  localparam logic [ADDR_W-1:0] LINE_STATUS_ADDR = 32'h5000_1104;
  localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 32'h5000_1108;
  localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 32'h5000_110C;

  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_FIFO_EN_BIT = 0;
  localparam int unsigned CTRL_IR_MODE_BIT = 1;
  localparam int unsigned LSR_DATA_READY_BIT = 0;
  localparam int unsigned LSR_OVERRUN_BIT = 1;
  localparam int unsigned LSR_THR_EMPTY_BIT = 5;
  localparam int unsigned LSR_TX_IDLE_BIT = 6;
  localparam int unsigned INT_RX_BIT = 0;
  localparam int unsigned INT_OVERRUN_BIT = 1;
  localparam int unsigned INT_THR_EMPTY_BIT = 2;

  // ==========================================================
  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 3'h0;
  localparam logic [INT_W-1:0] INT_STATUS_RESET = 3'h0;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DATA_W-1:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic valid;
    logic [BYTE_W-1:0] data;
  } char_s;

endpackage : uart_shadow_pkg

// file: logic/byte_fifo.sv
// Byte FIFO held in flip-flops, used for both receive and transmit paths.
// Assumes the caller pops only a non-empty FIFO; a push when full is dropped
// unless a pop happens in the same cycle.
`timescale 1ns/1ns
module byte_fifo (
  input wire logic clk, // System clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic flush, // Empties the FIFO.
  input wire logic push, // Offer of one byte.
  input wire logic [uart_shadow_pkg::BYTE_W-1:0] pushData, // Byte offered.
  input wire logic pop, // Removes the oldest byte.
  output logic [uart_shadow_pkg::BYTE_W-1:0] headData, // Oldest byte.
  output logic full, // All entries hold data.
  output logic empty, // No entry holds data.
  output logic [uart_shadow_pkg::LEVEL_W-1:0] level // Number of entries used.
);
  import uart_shadow_pkg::*;

  logic [BYTE_W-1:0] mem_r [FIFO_DEPTH];
  logic [IDX_W-1:0] wrPtr_r;
  logic [IDX_W-1:0] rdPtr_r;
  logic [LEVEL_W-1:0] count_r;
  logic doPop;
  logic doPush;

  // A pop is honoured only with data present; a full FIFO takes a push only alongside a pop.
  assign doPop = pop & ~empty;
  assign doPush = push & (~full | doPop);
  assign full = (count_r == LEVEL_W'(FIFO_DEPTH));
  assign empty = (count_r == '0);
  assign level = count_r;
  assign headData = mem_r[rdPtr_r];

  // Storage writes at the write pointer.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        mem_r[i] <= BYTE_RESET;
      end
    end else if (doPush && !flush) begin
      mem_r[wrPtr_r] <= pushData;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doPop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      if (doPush && !doPop) begin
        count_r <= count_r + 1'b1;
      end else if (doPop && !doPush) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : byte_fifo

// file: logic/uart_shadow_data_port.sv
// Data access part of a UART: sixteen aliased shadow words reach the receive
// buffer or receive FIFO on reads and the transmit holding byte or transmit
// FIFO on writes, plus line status, control, and interrupt registers.
// Assumes a classic Wishbone master and character strobes from an external
// serializer and deserializer running on the same clock.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
module uart_shadow_data_port (
  input wire logic clk, // System clock, 20 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire uart_shadow_pkg::wb_req_s wbReq, // Wishbone request group.
  output logic wbAck, // Wishbone acknowledge.
  output logic [uart_shadow_pkg::DATA_W-1:0] wbDatOut, // Wishbone read data.
  input wire uart_shadow_pkg::char_s uartRx, // Character from the UART input.
  input wire uart_shadow_pkg::char_s irRx, // Character from the infrared input.
  output uart_shadow_pkg::char_s txChar, // Character for the serializer.
  output logic txToIr, // Selects the infrared output for txChar.
  input wire logic txTake, // Serializer takes txChar this cycle.
  output logic irq // Level interrupt, active high.
);
  import uart_shadow_pkg::*;

  // ==========================================================
  // Address decoding

  // Matches any word of the aliased shadow window.
  function automatic logic isShadow(input logic [ADDR_W-1:0] adr);
    isShadow = (adr >= SHADOW_FIRST_ADDR) && (adr <= SHADOW_LAST_ADDR) &&
               (adr[1:0] == 2'b00);
  endfunction : isShadow

  logic wbAck_r;
  logic [DATA_W-1:0] wbDat_r;
  logic [DATA_W-1:0] rdData_nxt;
  logic accept;
  logic wrAcc;
  logic rdAcc;
  logic shadowHit;
  logic shadowWr;
  logic shadowRd;
  logic ctrlWr;
  logic maskWr;
  logic lineStatusRd;
  logic intStatusRd;

  // A request is taken once, in the cycle before its acknowledge.
  assign accept = wbReq.cyc & wbReq.stb & ~wbAck_r;
  assign wrAcc = accept & wbReq.we;
  assign rdAcc = accept & ~wbReq.we;
  assign shadowHit = isShadow(wbReq.adr);
  assign shadowWr = wrAcc & shadowHit & wbReq.sel[0];
  assign shadowRd = rdAcc & shadowHit;
  assign ctrlWr = wrAcc & (wbReq.adr == CTRL_ADDR) & wbReq.sel[0];
  assign maskWr = wrAcc & (wbReq.adr == INT_MASK_ADDR) & wbReq.sel[0];
  assign lineStatusRd = rdAcc & (wbReq.adr == LINE_STATUS_ADDR);
  assign intStatusRd = rdAcc & (wbReq.adr == INT_STATUS_ADDR);

  // ==========================================================
  // Control register

  logic [CTRL_W-1:0] ctrl_r;
  logic fifoEn;
  logic irMode;
  logic fifoFlush;

  assign fifoEn = ctrl_r[CTRL_FIFO_EN_BIT];
  assign irMode = ctrl_r[CTRL_IR_MODE_BIT];
  // Changing the FIFO mode empties both FIFOs so no stale byte survives.
  assign fifoFlush = ctrlWr & (wbReq.dat[CTRL_FIFO_EN_BIT] != fifoEn);

  // Holds FIFO enable and infrared mode select.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (ctrlWr) begin
      ctrl_r <= wbReq.dat[CTRL_W-1:0];
    end
  end

  // ==========================================================
  // Receive path

  char_s rxIn;
  logic [BYTE_W-1:0] rxBuf_r;
  logic rxBufValid_r;
  logic [BYTE_W-1:0] rxHeadData;
  logic rxFull;
  logic rxEmpty;
  logic rxPush;
  logic rxPop;
  logic rxDrop;
  logic rxOverwrite;
  logic overrunEvt;
  logic overrun_r;
  logic dataReady;
  logic [BYTE_W-1:0] rxHead;

  // The active input depends on the line mode.
  assign rxIn = irMode ? irRx : uartRx;
  assign rxPush = fifoEn & rxIn.valid;
  assign rxPop = shadowRd & fifoEn & ~rxEmpty;
  // A character meeting a full FIFO is lost unless a read frees a slot.
  assign rxDrop = rxPush & rxFull & ~rxPop;
  // A character meeting an unread buffer replaces it.
  assign rxOverwrite = ~fifoEn & rxIn.valid & rxBufValid_r & ~shadowRd;
  assign overrunEvt = rxDrop | rxOverwrite;
  assign dataReady = fifoEn ? ~rxEmpty : rxBufValid_r;
  assign rxHead = fifoEn ? rxHeadData : rxBuf_r;

  byte_fifo u_rx_fifo (
    .clk(clk),
    .resetn(resetn),
    .flush(fifoFlush),
    .push(rxPush),
    .pushData(rxIn.data),
    .pop(rxPop),
    .headData(rxHeadData),
    .full(rxFull),
    .empty(rxEmpty),
    .level()
  );

  // Single receive buffer used with FIFOs off; a new byte always lands.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxBuf_r <= BYTE_RESET;
    end else if (!fifoEn && rxIn.valid) begin
      rxBuf_r <= rxIn.data;
    end
  end

  // Buffer full flag; an arrival wins over the clearing read.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxBufValid_r <= 1'b0;
    end else if (!fifoEn && rxIn.valid) begin
      rxBufValid_r <= 1'b1;
    end else if (shadowRd || fifoEn) begin
      rxBufValid_r <= 1'b0;
    end
  end

  // Sticky overrun flag, cleared by a line status read; the event wins.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overrun_r <= 1'b0;
    end else if (overrunEvt) begin
      overrun_r <= 1'b1;
    end else if (lineStatusRd) begin
      overrun_r <= 1'b0;
    end
  end

  // ==========================================================
  // Transmit path

  logic [BYTE_W-1:0] holdByte_r;
  logic holdFull_r;
  logic [BYTE_W-1:0] txHeadData;
  logic txFull;
  logic txEmpty;
  logic txPop;
  logic stageFree;
  logic srcValid;
  logic [BYTE_W-1:0] srcData;
  logic txLoad;
  logic thrEmpty;
  logic thrEmptyPrev_r;
  char_s txChar_r;
  logic txToIr_r;

  assign stageFree = ~txChar_r.valid | txTake;
  assign srcValid = fifoEn ? ~txEmpty : holdFull_r;
  assign srcData = fifoEn ? txHeadData : holdByte_r;
  assign txLoad = stageFree & srcValid;
  assign txPop = txLoad & fifoEn;
  assign thrEmpty = fifoEn ? txEmpty : ~holdFull_r;

  // The FIFO refuses a write when full, unless a pop frees a slot in that cycle, and keeps its contents.
  byte_fifo u_tx_fifo (
    .clk(clk),
    .resetn(resetn),
    .flush(fifoFlush),
    .push(shadowWr & fifoEn),
    .pushData(wbReq.dat[BYTE_W-1:0]),
    .pop(txPop),
    .headData(txHeadData),
    .full(txFull),
    .empty(txEmpty),
    .level()
  );

  // Holding byte with FIFOs off; each write replaces what is pending.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      holdByte_r <= BYTE_RESET;
    end else if (shadowWr && !fifoEn) begin
      holdByte_r <= wbReq.dat[BYTE_W-1:0];
    end
  end

  // Holding full flag; a write wins over the hand-off to the serializer.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      holdFull_r <= 1'b0;
    end else if (shadowWr && !fifoEn) begin
      holdFull_r <= 1'b1;
    end else if (txLoad || fifoEn) begin
      holdFull_r <= 1'b0;
    end
  end

  // Output stage toward the serializer, with its line selection.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txChar_r <= '0;
      txToIr_r <= 1'b0;
    end else if (txLoad) begin
      txChar_r <= '{valid: 1'b1, data: srcData};
      txToIr_r <= irMode;
    end else if (txTake) begin
      txChar_r.valid <= 1'b0;
    end
  end

  // Remembers the empty flag to see it rise.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      thrEmptyPrev_r <= 1'b1;
    end else begin
      thrEmptyPrev_r <= thrEmpty;
    end
  end

  // ==========================================================
  // Interrupts

  logic [INT_W-1:0] intStatus_r;
  logic [INT_W-1:0] intMask_r;
  logic [INT_W-1:0] intEvt;
  logic irq_r;

  assign intEvt[INT_RX_BIT] = rxIn.valid & ~rxDrop;
  assign intEvt[INT_OVERRUN_BIT] = overrunEvt;
  assign intEvt[INT_THR_EMPTY_BIT] = thrEmpty & ~thrEmptyPrev_r;

  // Sticky status cleared by its own read; new events survive the read.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      intStatus_r <= INT_STATUS_RESET;
    end else if (intStatusRd) begin
      intStatus_r <= intEvt;
    end else begin
      intStatus_r <= intStatus_r | intEvt;
    end
  end

  // Interrupt mask, one bit per status bit.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      intMask_r <= INT_MASK_RESET;
    end else if (maskWr) begin
      intMask_r <= wbReq.dat[INT_W-1:0];
    end
  end

  // Interrupt level follows any unmasked status bit.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(intStatus_r & intMask_r);
    end
  end

  // ==========================================================
  // Bus answer

  // Read data selection; unmapped addresses read zero.
  always_comb begin
    rdData_nxt = DATA_RESET;
    if (shadowHit) begin
      rdData_nxt[BYTE_W-1:0] = rxHead;
    end else if (wbReq.adr == CTRL_ADDR) begin
      rdData_nxt[CTRL_W-1:0] = ctrl_r;
    end else if (wbReq.adr == LINE_STATUS_ADDR) begin
      rdData_nxt[LSR_DATA_READY_BIT] = dataReady;
      rdData_nxt[LSR_OVERRUN_BIT] = overrun_r;
      rdData_nxt[LSR_THR_EMPTY_BIT] = thrEmpty;
      rdData_nxt[LSR_TX_IDLE_BIT] = thrEmpty & ~txChar_r.valid;
    end else if (wbReq.adr == INT_STATUS_ADDR) begin
      rdData_nxt[INT_W-1:0] = intStatus_r;
    end else if (wbReq.adr == INT_MASK_ADDR) begin
      rdData_nxt[INT_W-1:0] = intMask_r;
    end
  end

  // Acknowledge one cycle after a request is taken, with its read data.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wbAck_r <= 1'b0;
      wbDat_r <= DATA_RESET;
    end else begin
      wbAck_r <= accept;
      wbDat_r <= rdAcc ? rdData_nxt : DATA_RESET;
    end
  end

  assign wbAck = wbAck_r;
  assign wbDatOut = wbDat_r;
  assign txChar = txChar_r;
  assign txToIr = txToIr_r;
  assign irq = irq_r;

endmodule : uart_shadow_data_port

// file: bench/uart_shadow_data_port_properties.sv
// Port-level checker for the shadow data port.
// Assumes one clock, clk, and the asynchronous active-low reset resetn.
`timescale 1ns/1ns
module uart_shadow_data_port_properties (
  input wire logic clk, // Clock.
  input wire logic resetn, // Reset, active low.
  input wire uart_shadow_pkg::wb_req_s wbReq, // Bus request.
  input wire logic wbAck, // Bus acknowledge.
  input wire logic [uart_shadow_pkg::DATA_W-1:0] wbDatOut, // Read data.
  input wire uart_shadow_pkg::char_s uartRx, // UART input strobe.
  input wire uart_shadow_pkg::char_s irRx, // Infrared input strobe.
  input wire uart_shadow_pkg::char_s txChar, // Offered character.
  input wire logic txToIr, // Infrared select.
  input wire logic txTake, // Serializer take.
  input wire logic irq // Interrupt.
);
  import uart_shadow_pkg::*;
  logic taken;
  logic wrTaken;
  logic shadowHit;
  logic rxSel;
  logic [CTRL_W-1:0] ctrl_r;
  logic [INT_W-1:0] mask_r;
  // ==========================================================
  // Decodes of the bus and of the receive input that the mode selects.
  assign taken = wbReq.cyc && wbReq.stb && !wbAck;
  assign wrTaken = taken && wbReq.we && wbReq.sel[0];
  assign shadowHit = wbReq.adr >= SHADOW_FIRST_ADDR && wbReq.adr <= SHADOW_LAST_ADDR;
  assign rxSel = ctrl_r[CTRL_IR_MODE_BIT] ? irRx.valid : uartRx.valid;
  // Mirrors of control and mask, updated at the edge that takes a write.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RESET;
      mask_r <= INT_MASK_RESET;
    end else if (wrTaken && wbReq.adr == CTRL_ADDR) begin
      ctrl_r <= wbReq.dat[CTRL_W-1:0];
    end else if (wrTaken && wbReq.adr == INT_MASK_ADDR) begin
      mask_r <= wbReq.dat[INT_W-1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Bus answer timing and read data.
  AST_ACK_NEXT: assert property (taken && shadowHit |=> wbAck)
    else $error("shadow access not acknowledged in the next cycle");
  AST_ACK_PULSE: assert property (wbAck |=> !wbAck)
    else $error("acknowledge longer than one cycle");
  AST_DAT_IDLE: assert property (!wbAck |-> wbDatOut == DATA_RESET)
    else $error("read data not zero outside acknowledge");
  AST_SHADOW_UPPER: assert property (wbAck && !wbReq.we && shadowHit |->
    wbDatOut[31:8] == 24'h0)
    else $error("upper shadow bits not zero");
  AST_RESET_QUIET: assert property ($rose(resetn) |-> !wbAck && !irq && !txChar.valid)
    else $error("outputs active at reset release");
  // ==========================================================
  // Transmit stage and interrupt.
  AST_TX_STANDS: assert property (txChar.valid && !txTake |=>
    txChar.valid && $stable(txChar.data))
    else $error("offered character changed before take");
  AST_IR_LATCH: assert property ($rose(txChar.valid) |-> txToIr == ctrl_r[CTRL_IR_MODE_BIT])
    else $error("output select differs from mode");
  AST_IRQ_RX: assert property (rxSel && mask_r[INT_RX_BIT] |-> ##2 irq)
    else $error("unmasked receive event gave no interrupt");
  AST_IRQ_QUIET: assert property (mask_r == INT_MASK_RESET |=> !irq)
    else $error("interrupt with all events masked");
  COV_IRQ: cover property ($rose(irq));
  COV_TAKE: cover property (txChar.valid && txTake);
  COV_SHADOW_RD: cover property (wbAck && !wbReq.we && shadowHit);
endmodule : uart_shadow_data_port_properties

bind uart_shadow_data_port uart_shadow_data_port_properties i_props (.clk(clk), .resetn(resetn),
  .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut), .uartRx(uartRx), .irRx(irRx),
  .txChar(txChar), .txToIr(txToIr), .txTake(txTake), .irq(irq));

// file: bench/far_uart_model.sv
// Far-side serial model: sends characters in and takes offered ones.
// Assumes the bench calls send and steers hold to stall the serializer.
`timescale 1ns/1ns
module far_uart_model (
  input wire logic clk, // Shared clock.
  input wire logic hold, // Stalls the serializer while high.
  output uart_shadow_pkg::char_s uartRx, // UART receive strobe.
  output uart_shadow_pkg::char_s irRx, // Infrared receive strobe.
  input wire uart_shadow_pkg::char_s txChar, // Offered character.
  output logic txTake // Take pulse.
);
  import uart_shadow_pkg::*;
  integer seed = 18;
  // ==========================================================
  // Lines start idle.
  initial begin
    uartRx = '0;
    irRx = '0;
    txTake = 1'h0;
  end
  // Takes an offered character after a random wait, so both fast and slow.
  always @(posedge clk) begin
    txTake <= !hold && txChar.valid && ($random(seed) % 2 != 0);
  end
  // One-cycle strobe; afterwards each data line shows its own previous byte inverted.
  task automatic send(input logic ir, input logic [BYTE_W-1:0] b);
    @(posedge clk);
    if (ir) irRx <= '{1'h1, b};
    else uartRx <= '{1'h1, b};
    @(posedge clk);
    uartRx <= '{1'h0, ~uartRx.data};
    irRx <= '{1'h0, ~irRx.data};
  endtask : send
endmodule : far_uart_model

// file: bench/uart_shadow_data_port_tb.sv
// Self-checking bench for the shadow data port with a far-side model.
// Assumes package, design, model and checker are compiled before it.
`timescale 1ns/1ns
module uart_shadow_data_port_tb;
  import uart_shadow_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic hold = 1'h1;
  wb_req_s wbReq = '0;
  logic wbAck;
  logic [DATA_W-1:0] wbDatOut;
  char_s uartRx;
  char_s irRx;
  char_s txChar;
  logic txToIr;
  logic txTake;
  logic irq;
  logic [63:0] rdQ[$];
  logic [8:0] txQ[$];
  logic [63:0] note;
  logic [7:0] b [0:17];
  integer seed = 18;
  int errorCnt = 0;
  int checks = 0;
  int cycleCnt = 0;
  uart_shadow_data_port i_dut (.clk(clk), .resetn(resetn), .wbReq(wbReq), .wbAck(wbAck),
    .wbDatOut(wbDatOut), .uartRx(uartRx), .irRx(irRx), .txChar(txChar), .txToIr(txToIr),
    .txTake(txTake), .irq(irq));
  far_uart_model i_far (.clk(clk), .hold(hold), .uartRx(uartRx), .irRx(irRx),
    .txChar(txChar), .txTake(txTake));
  // ==========================================================
  // Clock at 50 ns.
  always #25 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Prints the verdict and ends the run.
  task automatic closeOut();
    if (errorCnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : closeOut
  // One classic cycle; a read notes its expected value under a mask.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [31:0] m);
    @(posedge clk);
    wbReq <= '{1'h1, 1'h1, w, a, 4'hF, d};
    if (!w) rdQ.push_back({m, d});
    do @(posedge clk); while (wbAck !== 1'h1);
    wbReq <= '0;
  endtask : bus
  // Lets the serializer run until every expected character is out.
  task automatic drain();
    @(posedge clk);
    hold <= 1'h0;
    while (txQ.size() > 0) @(posedge clk);
    hold <= 1'h1;
  endtask : drain
  function automatic logic [31:0] sh();
    return SHADOW_FIRST_ADDR + 32'(($random(seed) & 15) * 4);
  endfunction : sh
  // Takes the oldest note when read data appears and the oldest expected character when one is taken.
  always @(posedge clk) begin
    if (wbAck === 1'h1 && wbReq.we === 1'h0) begin
      note = rdQ.size() > 0 ? rdQ.pop_front() : 64'h1;
      chk(wbDatOut & note[63:32], note[31:0]);
    end
    if (txChar.valid === 1'h1 && txTake === 1'h1) begin
      chk({txToIr, txChar.data}, txQ.size() > 0 ? txQ.pop_front() : 32'h1FF);
    end
    cycleCnt++;
    if (cycleCnt > 20000) begin
      errorCnt++;
      closeOut();
    end
  end
  // ==========================================================
  // Main sequence.
  initial begin
    for (int i = 0; i < 18; i++) b[i] = 8'($random(seed));
    repeat (10) @(posedge clk);
    resetn <= 1'h1;
    bus(1'h0, CTRL_ADDR, DATA_RESET, ALL);
    bus(1'h0, INT_MASK_ADDR, DATA_RESET, ALL);
    bus(1'h0, LINE_STATUS_ADDR, 32'h60, ALL);
    bus(1'h0, 32'h5000_1200, DATA_RESET, ALL);
    // FIFOs off: the second character overwrites the first.
    i_far.send(1'h0, b[0]);
    i_far.send(1'h0, b[1]);
    bus(1'h0, LINE_STATUS_ADDR, 32'h3, 32'h3);
    bus(1'h0, sh(), {24'h0, b[1]}, ALL);
    bus(1'h0, LINE_STATUS_ADDR, DATA_RESET, 32'h1);
    // FIFOs off with the stage stalled: the pending byte is replaced.
    bus(1'h1, sh(), {24'($random(seed)), b[2]}, ALL);
    bus(1'h1, sh(), {24'($random(seed)), b[3]}, ALL);
    bus(1'h0, LINE_STATUS_ADDR, DATA_RESET, 32'h20);
    bus(1'h1, sh(), {24'($random(seed)), b[4]}, ALL);
    txQ.push_back({1'h0, b[2]});
    txQ.push_back({1'h0, b[4]});
    drain();
    bus(1'h0, LINE_STATUS_ADDR, 32'h60, 32'h60);
    // FIFOs on, infrared mode: seventeen in, the last one lost.
    bus(1'h1, CTRL_ADDR, 32'h3, ALL);
    bus(1'h0, CTRL_ADDR, 32'h3, ALL);
    for (int i = 0; i < 17; i++) i_far.send(1'h1, b[i]);
    for (int i = 0; i < 16; i++) bus(1'h0, sh(), {24'h0, b[i]}, ALL);
    bus(1'h0, LINE_STATUS_ADDR, 32'h2, 32'h3);
    // One byte in the stage, sixteen queued, the eighteenth dropped.
    for (int i = 0; i < 18; i++) bus(1'h1, sh(), {24'($random(seed)), b[i]}, ALL);
    bus(1'h0, LINE_STATUS_ADDR, DATA_RESET, 32'h20);
    for (int i = 0; i < 17; i++) txQ.push_back({1'h1, b[i]});
    drain();
    bus(1'h0, LINE_STATUS_ADDR, 32'h60, 32'h60);
    // Interrupt: masked event, unmask, read-clear, unmasked event.
    bus(1'h0, INT_STATUS_ADDR, 32'h3, 32'h3);
    i_far.send(1'h1, b[6]);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, DATA_RESET);
    bus(1'h1, INT_MASK_ADDR, 32'h1, ALL);
    bus(1'h0, INT_STATUS_ADDR, 32'h1, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, DATA_RESET);
    i_far.send(1'h1, b[7]);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    closeOut();
  end
endmodule : uart_shadow_data_port_tb
